// ===== core/dma_cfg.svh
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// Register byte offsets
`define DMA_OFF_PTR    8'h00
`define DMA_OFF_MAXLEN 8'h04
`define DMA_OFF_TRANSFERRED_BYTE_COUNT 8'h08
`define DMA_OFF_LIST   8'h0C
`define DMA_OFF_CTRL   8'h10
`define DMA_OFF_STATUS 8'h14

// Control bits (write only, self clearing)
`define DMA_CTRL_START 0
`define DMA_CTRL_STOP  1

// Status bits
`define DMA_ST_BUSY    0
`define DMA_ST_DONE    1
`define DMA_ST_ADDRERR 2
`define DMA_ST_BUSERR  3
`define DMA_ST_LOST    4

// List mode select value
`define DMA_LIST_LINEAR 1'b1

// Reset values
`define DMA_RST_PTR    32'h0000_0000
`define DMA_RST_MAXLEN 16'h0000

// Default data RAM window
`define DMA_RAM_BASE   32'h2000_0000
`define DMA_RAM_SIZE   32'h0000_6000

`endif

// ===== core/dma_pkg.sv
package dma_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ADDR = 3'h2,
		ST_DATA = 3'h4
	} beat_state_t;

	typedef enum logic [1:0] {
		TR_IDLE   = 2'h0,
		TR_NONSEQ = 2'h2
	} htrans_t;

endpackage : dma_pkg

// ===== core/peripheral_ram_dma_channel.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "dma_cfg.svh"

module dma_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         ref_clk,   // Clock
	input  wire logic         rst_n,     // Sync reset
	input  wire logic         in_valid,  // Fill side valid
	input  wire logic [W-1:0] in_data,   // Fill side data
	output logic              in_ready,  // Fill side ready
	output logic              out_valid, // Drain side valid
	output logic [W-1:0]      out_data,  // Drain side data
	input  wire logic         out_ready  // Drain side ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wr_reg, wr_next;
	logic [AW-1:0] rd_reg, rd_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          full_reg, full_next;
	logic          empty_reg, empty_next;
	logic          push;
	logic          pop;

	always_comb begin
		push = in_valid & ~full_reg;
		pop = out_ready & ~empty_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (push) begin
			wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
		end
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		full_next = (cnt_next == (AW+1)'(D));
		empty_next = (cnt_next == '0);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			full_reg <= full_next;
			empty_reg <= empty_next;
		end
	end

	// Storage needs no reset; empty flag guards it
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	assign in_ready = ~full_reg;
	assign out_valid = ~empty_reg;
	assign out_data = mem_reg[rd_reg];

endmodule : dma_fifo

module peripheral_ram_dma_channel #(
	parameter bit          WRITE_CHANNEL = 1'b1,           // 1: peripheral to RAM
	parameter bit          LIST_PRESENT  = 1'b1,           // List register exists
	parameter bit          DROP_ON_STALL = 1'b0,           // Peripheral drops data
	parameter int          CNT_W         = 16,             // Count width
	parameter int          FIFO_DEPTH    = 4,              // Buffer depth
	parameter logic [31:0] RAM_BASE      = `DMA_RAM_BASE,  // RAM window start
	parameter logic [31:0] RAM_SIZE      = `DMA_RAM_SIZE   // RAM window size
) (
	input  wire logic        ref_clk,    // 50 MHz clock
	input  wire logic        rst_n,      // Sync reset, active low
	input  wire logic [7:0]  reg_addr,   // Register byte address
	input  wire logic [31:0] reg_wdata,  // Register write data
	input  wire logic        reg_wr,     // Write strobe
	input  wire logic        reg_rd,     // Read strobe
	output logic [31:0]      reg_rdata,  // Read data, one cycle later
	output logic [31:0]      haddr,      // Bus address
	output logic [1:0]       htrans,     // Bus transfer type
	output logic             hwrite,     // Bus write
	output logic [2:0]       hsize,      // Bus size, always byte
	output logic [31:0]      hwdata,     // Bus write data
	input  wire logic [31:0] hrdata,     // Bus read data
	input  wire logic        hready,     // Bus ready / grant
	input  wire logic        hresp,      // Bus error response
	input  wire logic        src_valid,  // Peripheral byte valid
	input  wire logic [7:0]  src_data,   // Peripheral byte
	output logic             src_ready,  // Channel takes byte
	output logic             snk_valid,  // Byte for peripheral
	output logic [7:0]       snk_data,   // Byte to peripheral
	input  wire logic        snk_ready   // Peripheral takes byte
);
	dma_pkg::beat_state_t st_reg, st_next;

	logic [31:0]      ptr_reg, ptr_next;
	logic [CNT_W-1:0] max_reg, max_next;
	logic [CNT_W-1:0] amt_reg, amt_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [31:0]      cur_reg, cur_next;
	logic             list_reg, list_next;
	logic             busy_reg, busy_next;
	logic             done_reg, done_next;
	logic             aerr_reg, aerr_next;
	logic             berr_reg, berr_next;
	logic             lost_reg, lost_next;
	logic             stop_reg, stop_next;
	logic [7:0]       byte_reg, byte_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [31:0]      haddr_reg, haddr_next;
	logic [1:0]       htrans_reg, htrans_next;
	logic             hwrite_reg, hwrite_next;
	logic [31:0]      hwdata_reg, hwdata_next;

	logic             fill_valid, fill_ready;
	logic [7:0]       fill_data;
	logic             drain_valid, drain_ready;
	logic [7:0]       drain_data;
	logic             wr_ptr, wr_max, wr_list, wr_ctrl, wr_stat;
	logic             finish;
	logic [31:0]      end_addr;
	logic [7:0]       lane_byte;

	// Peripheral fills on a write channel, the bus fills on a read channel
	dma_fifo #(
		.W (8),
		.D (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (fill_valid),
		.in_data   (fill_data),
		.in_ready  (fill_ready),
		.out_valid (drain_valid),
		.out_data  (drain_data),
		.out_ready (drain_ready)
	);

	always_comb begin
		wr_ptr = reg_wr & (reg_addr == `DMA_OFF_PTR);
		wr_max = reg_wr & (reg_addr == `DMA_OFF_MAXLEN);
		wr_list = reg_wr & (reg_addr == `DMA_OFF_LIST);
		wr_ctrl = reg_wr & (reg_addr == `DMA_OFF_CTRL);
		wr_stat = reg_wr & (reg_addr == `DMA_OFF_STATUS);
		lane_byte = hrdata[{cur_reg[1:0], 3'b000} +: 8];
		end_addr = ptr_reg + 32'(max_reg);
	end

	// Byte streams and the peripheral handshake
	always_comb begin
		fill_valid = 1'b0;
		fill_data = lane_byte;
		drain_ready = 1'b0;
		if (WRITE_CHANNEL) begin
			fill_valid = src_valid;
			fill_data = src_data;
		end else begin
			drain_ready = snk_ready;
		end
		if (WRITE_CHANNEL && st_reg == dma_pkg::ST_IDLE && busy_reg && !stop_reg
			&& cnt_reg != max_reg) begin
			drain_ready = 1'b1;
		end
		if (!WRITE_CHANNEL && st_reg == dma_pkg::ST_DATA && hready && !hresp) begin
			fill_valid = 1'b1;
		end
	end

	always_comb begin
		st_next = st_reg;
		ptr_next = ptr_reg;
		max_next = max_reg;
		amt_next = amt_reg;
		cnt_next = cnt_reg;
		cur_next = cur_reg;
		list_next = list_reg;
		busy_next = busy_reg;
		done_next = done_reg;
		aerr_next = aerr_reg;
		berr_next = berr_reg;
		lost_next = lost_reg;
		stop_next = stop_reg;
		byte_next = byte_reg;
		haddr_next = haddr_reg;
		htrans_next = htrans_reg;
		hwrite_next = hwrite_reg;
		hwdata_next = hwdata_reg;
		finish = 1'b0;

		// Done, error and lost flags clear on write-one (busy does not); a set later in this block wins
		if (wr_stat) begin
			if (reg_wdata[`DMA_ST_DONE]) done_next = 1'b0;
			if (reg_wdata[`DMA_ST_ADDRERR]) aerr_next = 1'b0;
			if (reg_wdata[`DMA_ST_BUSERR]) berr_next = 1'b0;
			if (reg_wdata[`DMA_ST_LOST]) lost_next = 1'b0;
		end
		// Setup registers are frozen while a transfer runs
		if (!busy_reg) begin
			if (wr_ptr) ptr_next = reg_wdata;
			if (wr_max) max_next = reg_wdata[CNT_W-1:0];
			if (wr_list && LIST_PRESENT) list_next = reg_wdata[0];
		end
		// A dropping peripheral loses the byte the full buffer refused
		if (DROP_ON_STALL && WRITE_CHANNEL && src_valid && !fill_ready) begin
			lost_next = 1'b1;
		end
		if (wr_ctrl && reg_wdata[`DMA_CTRL_STOP] && busy_reg) begin
			stop_next = 1'b1;
		end

		unique case (st_reg)
			dma_pkg::ST_IDLE: begin
				if (busy_reg) begin
					if (stop_reg || cnt_reg == max_reg) begin
						finish = 1'b1;
					end else if (WRITE_CHANNEL && drain_valid) begin
						byte_next = drain_data;
						haddr_next = cur_reg;
						htrans_next = dma_pkg::TR_NONSEQ;
						hwrite_next = 1'b1;
						st_next = dma_pkg::ST_ADDR;
					end else if (!WRITE_CHANNEL && fill_ready) begin
						// Room is reserved before the read so returned data never drops
						haddr_next = cur_reg;
						htrans_next = dma_pkg::TR_NONSEQ;
						hwrite_next = 1'b0;
						st_next = dma_pkg::ST_ADDR;
					end
				end else if (wr_ctrl && reg_wdata[`DMA_CTRL_START]) begin
					// Refuse pointers outside data RAM instead of corrupting memory
					if (ptr_reg < RAM_BASE || end_addr > RAM_BASE + RAM_SIZE
						|| end_addr < ptr_reg) begin
						aerr_next = 1'b1;
						done_next = 1'b1;
						amt_next = '0;
					end else begin
						busy_next = 1'b1;
						cnt_next = '0;
						cur_next = ptr_reg;
					end
				end
			end
			dma_pkg::ST_ADDR: begin
				// Held off by a higher-priority master until granted
				if (hready) begin
					htrans_next = dma_pkg::TR_IDLE;
					hwdata_next = {4{byte_reg}};
					st_next = dma_pkg::ST_DATA;
				end
			end
			dma_pkg::ST_DATA: begin
				if (hready) begin
					st_next = dma_pkg::ST_IDLE;
					if (hresp) begin
						berr_next = 1'b1;
						stop_next = 1'b1;
					end else begin
						cnt_next = cnt_reg + 1'b1;
						cur_next = cur_reg + 32'h0000_0001;
					end
				end
			end
			default: begin
				st_next = dma_pkg::ST_IDLE;
			end
		endcase

		if (finish) begin
			busy_next = 1'b0;
			stop_next = 1'b0;
			done_next = 1'b1;
			amt_next = cnt_reg;
			// Next item sits right after this one; no link word is kept
			if (list_reg == `DMA_LIST_LINEAR && cnt_reg == max_reg) begin
				ptr_next = ptr_reg + 32'(max_reg);
			end
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`DMA_OFF_PTR:    rdata_next = ptr_reg;
				`DMA_OFF_MAXLEN: rdata_next = 32'(max_reg);
				`DMA_OFF_TRANSFERRED_BYTE_COUNT: rdata_next = 32'(amt_reg);
				`DMA_OFF_LIST:   rdata_next = {31'h0000_0000, list_reg};
				`DMA_OFF_STATUS: begin
					rdata_next[`DMA_ST_BUSY] = busy_reg;
					rdata_next[`DMA_ST_DONE] = done_reg;
					rdata_next[`DMA_ST_ADDRERR] = aerr_reg;
					rdata_next[`DMA_ST_BUSERR] = berr_reg;
					rdata_next[`DMA_ST_LOST] = lost_reg;
				end
				default:         rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= dma_pkg::ST_IDLE;
			ptr_reg <= `DMA_RST_PTR;
			max_reg <= `DMA_RST_MAXLEN;
			amt_reg <= '0;
			cnt_reg <= '0;
			cur_reg <= 32'h0000_0000;
			list_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			aerr_reg <= 1'b0;
			berr_reg <= 1'b0;
			lost_reg <= 1'b0;
			stop_reg <= 1'b0;
			byte_reg <= 8'h00;
			rdata_reg <= 32'h0000_0000;
			haddr_reg <= 32'h0000_0000;
			htrans_reg <= dma_pkg::TR_IDLE;
			hwrite_reg <= 1'b0;
			hwdata_reg <= 32'h0000_0000;
		end else begin
			st_reg <= st_next;
			ptr_reg <= ptr_next;
			max_reg <= max_next;
			amt_reg <= amt_next;
			cnt_reg <= cnt_next;
			cur_reg <= cur_next;
			list_reg <= list_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			aerr_reg <= aerr_next;
			berr_reg <= berr_next;
			lost_reg <= lost_next;
			stop_reg <= stop_next;
			byte_reg <= byte_next;
			rdata_reg <= rdata_next;
			haddr_reg <= haddr_next;
			htrans_reg <= htrans_next;
			hwrite_reg <= hwrite_next;
			hwdata_reg <= hwdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign haddr = haddr_reg;
	assign htrans = htrans_reg;
	assign hwrite = hwrite_reg;
	assign hsize = 3'h0;
	assign hwdata = hwdata_reg;
	assign src_ready = WRITE_CHANNEL ? fill_ready : 1'b0;
	assign snk_valid = WRITE_CHANNEL ? 1'b0 : drain_valid;
	assign snk_data = WRITE_CHANNEL ? 8'h00 : drain_data;

endmodule : peripheral_ram_dma_channel

`default_nettype wire

// ===== test/dma_chan_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dma_chan_chk #(
	parameter bit          WRITE_CHANNEL = 1'b1,  // Direction
	parameter logic [31:0] RAM_BASE      = 32'h0, // Window start
	parameter logic [31:0] RAM_SIZE      = 32'h0  // Window size
) (
	input wire logic        ref_clk,   // Clock
	input wire logic        rst_n,     // Sync reset
	input wire logic        reg_rd,    // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic [31:0] haddr,     // Bus address
	input wire logic [1:0]  htrans,    // Transfer type
	input wire logic        hwrite,    // Bus write
	input wire logic [2:0]  hsize,     // Bus size
	input wire logic [31:0] hwdata,    // Write data
	input wire logic        hready,    // Bus ready
	input wire logic        snk_valid, // Sink valid
	input wire logic [7:0]  snk_data   // Sink data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_byte_size: assert property (htrans == 2'h2 |-> hsize == 3'h0)
		else $error("Bus size is not byte");
	chk_addr_hold: assert property (htrans == 2'h2 && !hready |=> htrans == 2'h2 && $stable(haddr))
		else $error("Address phase dropped during stall");
	chk_ram_only: assert property (htrans == 2'h2 |-> haddr >= RAM_BASE && haddr - RAM_BASE < RAM_SIZE)
		else $error("Address outside data RAM");
	chk_beat_gap: assert property (htrans == 2'h2 && hready |=> htrans == 2'h0)
		else $error("No data phase after address");
	chk_idle_first: assert property (htrans == 2'h2 && $past(htrans) == 2'h2 |-> !$past(hready))
		else $error("Address phase repeated after acceptance");
	chk_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("Read data without read strobe");
	chk_dir_write: assert property (htrans == 2'h2 |-> hwrite == WRITE_CHANNEL)
		else $error("Beat direction wrong");
	chk_sink_idle: assert property (WRITE_CHANNEL |-> !snk_valid)
		else $error("Sink active on write channel");
	chk_sink_data: assert property (WRITE_CHANNEL |-> snk_data == 8'h00)
		else $error("Sink data driven on write channel");
	chk_lane_copy: assert property (htrans == 2'h2 && hready |=> hwdata == {4{hwdata[7:0]}})
		else $error("Byte not on all lanes");
endmodule : dma_chan_chk
bind peripheral_ram_dma_channel dma_chan_chk #(.WRITE_CHANNEL(WRITE_CHANNEL), .RAM_BASE(RAM_BASE),
	.RAM_SIZE(RAM_SIZE)) chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.snk_valid(snk_valid), .snk_data(snk_data));
`default_nettype wire

// ===== test/ram_partner.sv
`timescale 1ns/1ns
`default_nettype none
module ram_partner (
	input wire logic        ref_clk,  // Clock
	input wire logic        rst_n,    // Sync reset
	input wire logic        stall_en, // Random wait states
	input wire logic        err_en,   // Error injection
	input wire logic [31:0] haddr,    // Bus address
	input wire logic [1:0]  htrans,   // Transfer type
	input wire logic        hwrite,   // Bus write
	input wire logic [31:0] hwdata,   // Write data
	output logic [31:0]     hrdata,   // Read data
	output logic            hready,   // Ready and grant
	output logic            hresp     // Error response
);
	logic [7:0]  mem [logic [31:0]];
	logic        dphase;
	logic        dwr;
	logic [31:0] daddr;
	logic [7:0]  noise = 8'hA5;
	assign hresp  = err_en & dphase; // Every data phase fails while injected
	assign hrdata = {4{noise}}; // Nobody drives read data, so it keeps moving
	always @(posedge ref_clk) begin
		noise <= noise + 8'h5B;
		if (!rst_n) begin
			dphase <= 1'b0;
			hready <= 1'b1;
		end else begin
			hready <= stall_en ? 1'($urandom_range(0, 1)) : 1'b1; // Higher priority master owns RAM
			if (hready) begin
				if (dphase && dwr)
					mem[daddr] = hwdata[8 * daddr[1:0] +: 8];
				dphase <= (htrans == 2'h2);
				daddr  <= haddr;
				dwr    <= hwrite;
			end
		end
	end
endmodule : ram_partner
`default_nettype wire

// ===== test/peripheral_ram_dma_channel_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dma_cfg.svh"
module peripheral_ram_dma_channel_bench;
	localparam logic [31:0] BASE = `DMA_RAM_BASE;
	logic        ref_clk   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        src_valid = 1'b0;
	logic [7:0]  src_data  = 8'h00;
	logic        stall_en  = 1'b0;
	logic        err_en    = 1'b0;
	logic [31:0] reg_rdata, haddr, hwdata, hrdata, rd_val, ptr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  snk_data;
	logic        hwrite, hready, hresp, src_ready, snk_valid;
	logic [7:0]  bytes_q [$];
	logic [7:0]  offs [5] = '{`DMA_OFF_PTR, `DMA_OFF_MAXLEN, `DMA_OFF_TRANSFERRED_BYTE_COUNT, `DMA_OFF_STATUS, 8'h40};
	int          n_mismatch = 0;
	int          compares   = 0;
	int          cnt;
	always #10 ref_clk = ~ref_clk;
	peripheral_ram_dma_channel dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp), .src_valid(src_valid),
		.src_data(src_data), .src_ready(src_ready), .snk_valid(snk_valid), .snk_data(snk_data), .snk_ready(1'b0));
	ram_partner ram (.ref_clk(ref_clk), .rst_n(rst_n), .stall_en(stall_en), .err_en(err_en), .haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	function automatic logic [31:0] mem_byte(input logic [31:0] a);
		return ram.mem.exists(a) ? {24'h0, ram.mem[a]} : 32'hFFFF_FFFF; // All ones marks a byte never written
	endfunction : mem_byte
	function automatic logic [31:0] exp_status(input bit bad);
		return bad ? 32'h0000_0006 : 32'h0000_0002;
	endfunction : exp_status
	// Bad starts push nothing and request a stop, which an idle channel ignores
	task automatic run(input logic [31:0] p, input int n, input bit load, input bit bad);
		int tries;
		bytes_q.delete();
		for (int i = 0; i < n; i++)
			bytes_q.push_back(8'($urandom));
		reg_write(`DMA_OFF_MAXLEN, 32'(n));
		if (load)
			reg_write(`DMA_OFF_PTR, p);
		reg_write(`DMA_OFF_CTRL, 32'h1);
		if (!bad) begin
			foreach (bytes_q[i]) begin
				src_valid <= 1'b1;
				src_data  <= bytes_q[i];
				@(posedge ref_clk);
				while (!src_ready)
					@(posedge ref_clk);
			end
		end else begin
			reg_write(`DMA_OFF_CTRL, 32'h2);
		end
		src_valid <= 1'b0;
		tries = 0;
		do
			reg_read(`DMA_OFF_STATUS, rd_val);
		while (rd_val[1] !== 1'b1 && ++tries < 100);
	endtask : run
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h056A08CD));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (offs[i]) begin
			reg_read(offs[i], rd_val);
			check(rd_val, 32'h0);
		end
		$display("Test reset values done");
		for (int k = 0; k < 4; k++) begin
			ptr = BASE + 32'h100 * k + $urandom_range(0, 3);
			cnt = (k == 0) ? 0 : $urandom_range(1, 8);
			stall_en <= k[0];
			run(ptr, cnt, 1'b1, 1'b0);
			check(rd_val, exp_status(1'b0));
			reg_read(`DMA_OFF_TRANSFERRED_BYTE_COUNT, rd_val);
			check(rd_val, 32'(cnt));
			foreach (bytes_q[i])
				check(mem_byte(ptr + i), {24'h0, bytes_q[i]});
			check(mem_byte(ptr + cnt), 32'hFFFF_FFFF);
			reg_write(`DMA_OFF_STATUS, 32'h1E);
		end
		$display("Test single buffers done");
		for (int k = 0; k < 2; k++) begin
			ptr = k ? BASE + `DMA_RAM_SIZE - 2 : 32'h0000_1000;
			run(ptr, 4, 1'b1, 1'b1);
			check(rd_val, exp_status(1'b1));
			reg_read(`DMA_OFF_TRANSFERRED_BYTE_COUNT, rd_val);
			check(rd_val, 32'h0);
			check(mem_byte(ptr), 32'hFFFF_FFFF);
			reg_write(`DMA_OFF_STATUS, 32'h1E);
		end
		$display("Test bad pointers done");
		// A started channel with no data ends at once on stop
		run(BASE + 32'h400, 8, 1'b1, 1'b1);
		check(rd_val, exp_status(1'b0));
		reg_read(`DMA_OFF_TRANSFERRED_BYTE_COUNT, rd_val);
		check(rd_val, 32'h0);
		check(mem_byte(BASE + 32'h400), 32'hFFFF_FFFF);
		reg_write(`DMA_OFF_STATUS, 32'h1E);
		$display("Test stop done");
		reg_write(`DMA_OFF_LIST, 32'h1);
		reg_read(`DMA_OFF_LIST, rd_val);
		check(rd_val, 32'h1);
		ptr = BASE + 32'h800;
		stall_en <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			run(ptr, 4, j == 0, 1'b0);
			check(rd_val, exp_status(1'b0));
			foreach (bytes_q[i])
				check(mem_byte(ptr + 4 * j + i), {24'h0, bytes_q[i]});
			reg_write(`DMA_OFF_STATUS, 32'h1E);
		end
		reg_read(`DMA_OFF_PTR, rd_val);
		check(rd_val, ptr + 32'h8);
		$display("Test list mode done");
		// A failed beat ends the buffer early, so the list must not advance
		err_en <= 1'b1;
		run(ptr, 1, 1'b0, 1'b0);
		check(rd_val, 32'h0000_000A);
		err_en <= 1'b0;
		reg_read(`DMA_OFF_TRANSFERRED_BYTE_COUNT, rd_val);
		check(rd_val, 32'h0);
		reg_read(`DMA_OFF_PTR, rd_val);
		check(rd_val, ptr + 32'h8);
		reg_write(`DMA_OFF_STATUS, 32'h1E);
		$display("Test bus error done");
		complete_run();
	end
endmodule : peripheral_ram_dma_channel_bench
`default_nettype wire
